//--- core/dcc_consts.svh
/*
  constants of the dual comparator control block: register offsets,
  bit positions, masks and reset values.
  assumes it is included by its bare name, once or more.
*/
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// word offsets on the bus (byte addresses)
`define DCC_ADR_CTRL 8'h00
`define DCC_ADR_ISTS 8'h04
`define DCC_ADR_IMSK 8'h08

// comparator control bit positions, first comparator on the lower bit
`define DCC_BIT_IDLE 15
`define DCC_BIT_FLAG 12
`define DCC_BIT_ON 10
`define DCC_BIT_PAD 8
`define DCC_BIT_RES 6
`define DCC_BIT_FLIP 4
`define DCC_BIT_MINUS_A 1
`define DCC_BIT_PLUS_A 0
`define DCC_BIT_MINUS_B 3
`define DCC_BIT_PLUS_B 2

// write masks and reset values
`define DCC_CTRL_WR_MASK 16'h8f3f
`define DCC_CTRL_RST 16'h0000
`define DCC_IRQ_RST 2'h0
`define DCC_ZERO32 32'h00000000
`define DCC_ZERO16 16'h0000

`endif

//--- core/dcc_pkg.sv
/*
  types shared by the dual comparator control block.
  assumes dcc_consts.svh holds the numeric constants.
*/
package dcc_pkg;

  // bus answer state
  typedef enum logic [0:0] {
    DCC_BUS_IDLE = 1'b0,
    DCC_BUS_ACK = 1'b1
  } dcc_bus_t;

  // one bit per comparator, index 0 is the first one
  typedef logic [1:0] dcc_pair_t;

endpackage

//--- core/dcc_chan_if.sv
/*
  carrier between the control register logic and one comparator channel.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface dcc_chan_if;
  logic on;
  logic pad_drive;
  logic flip;
  logic result;
  logic change;
  logic pad;
  logic pad_oe_n;

  // register side
  modport ctl (
    output on,
    output pad_drive,
    output flip,
    input result,
    input change,
    input pad,
    input pad_oe_n
  );

  // comparator channel side
  modport chan (
    input on,
    input pad_drive,
    input flip,
    output result,
    output change,
    output pad,
    output pad_oe_n
  );
endinterface

//--- core/dcc_chan.sv
/*
  one comparator channel: synchroniser, polarity flip, change detect, pad.
  assumes the raw comparator result is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module dcc_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic raw_i,
  dcc_chan_if.chan ch
);

  logic sync1_q;
  logic sync2_q;
  logic res_d;
  logic res_q;
  logic on_prev_q;
  logic on_prev2_q;
  logic on_prev3_q;
  logic chg_q;
  logic pad_q;
  logic oe_n_q;

  // two flops before anything looks at the analog result
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_q <= raw_i;
      sync2_q <= sync1_q;
    end
  end

  // a disabled comparator reads low; the flip applies after sync
  assign res_d = ch.on & (sync2_q ^ ch.flip);

  // result, change pulse and how long the enable has stood;
  // events wait until the synchroniser only holds samples taken while on,
  // so stale values from the off period never raise a false event
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_q <= 1'b0;
      on_prev_q <= 1'b0;
      on_prev2_q <= 1'b0;
      on_prev3_q <= 1'b0;
      chg_q <= 1'b0;
    end
    else if (ce_i)
    begin
      res_q <= res_d;
      on_prev_q <= ch.on;
      on_prev2_q <= on_prev_q & ch.on;
      on_prev3_q <= on_prev2_q & ch.on;
      chg_q <= ch.on & on_prev3_q & (res_d != res_q);
    end
  end

  // pad value and enable, enable low while the pad is driven
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (ce_i)
    begin
      pad_q <= res_d;
      oe_n_q <= ~ch.pad_drive;
    end
  end

  assign ch.result = res_q;
  assign ch.change = chg_q;
  assign ch.pad = pad_q;
  assign ch.pad_oe_n = oe_n_q;

endmodule

//--- core/dcc_top.sv
/*
  dual comparator control: control register, change flags, interrupt
  status and mask, on a classic wishbone slave with 32-bit data.
  assumes idle_i comes from logic on clk_i and cmp_raw_i from the
  asynchronous analog comparator cores.
*/
// Register access over Wishbone and the address map were decided locally.
// Function
// - idle bit set: no interrupts while idling
// - change sets flag; software clears only
// - enable bit switches each comparator on
// - pad enable bit drives result onto pad
// - bit 7 shows second comparator result
// - bit 6 shows first comparator result
// - flip bits invert each comparator output
// - bit 2 picks second plus pin or reference
// - bit 1 picks first minus input pin
// - bit 14 reads zero; all reset zero
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dcc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic idle_i,
  input wire logic [1:0] cmp_raw_i,
  output logic [1:0] cmp_on_o,
  output logic [1:0] plus_route_o,
  output logic [1:0] minus_route_o,
  output logic [1:0] pad_o,
  output logic [1:0] pad_oe_n_o,
  output logic irq_o
);

  dcc_pkg::dcc_bus_t bus_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [15:0] ctrl_q;
  dcc_pkg::dcc_pair_t flag_q;
  dcc_pkg::dcc_pair_t ists_q;
  dcc_pkg::dcc_pair_t imsk_q;
  logic irq_q;
  dcc_pkg::dcc_pair_t result;
  dcc_pkg::dcc_pair_t change;
  dcc_pkg::dcc_pair_t irq_set;
  logic suppress;
  logic req;
  logic wr;
  logic [15:0] lane_mask;
  logic wr_ctrl;
  logic wr_ists;
  logic wr_imsk;
  dcc_pkg::dcc_pair_t flag_clr;
  logic [15:0] ctrl_d;
  logic [15:0] ctrl_rd;
  logic [31:0] rdat_d;

  // a new request is seen only while no answer is pending
  assign req = wb_cyc_i & wb_stb_i & (bus_q == dcc_pkg::DCC_BUS_IDLE);
  assign wr = req & wb_we_i;

  // byte lanes 0 and 1 cover the 16-bit registers
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // address decode
  assign wr_ctrl = wr & (wb_adr_i == `DCC_ADR_CTRL);
  assign wr_ists = wr & (wb_adr_i == `DCC_ADR_ISTS);
  assign wr_imsk = wr & (wb_adr_i == `DCC_ADR_IMSK);

  // bus answer: ack one cycle after the request is taken, then idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_q <= dcc_pkg::DCC_BUS_IDLE;
      ack_q <= 1'b0;
    end
    else if (ce_i)
    begin
      unique case (bus_q)
        dcc_pkg::DCC_BUS_IDLE:
        begin
          if (req)
          begin
            bus_q <= dcc_pkg::DCC_BUS_ACK;
            ack_q <= 1'b1;
          end
        end
        dcc_pkg::DCC_BUS_ACK:
        begin
          bus_q <= dcc_pkg::DCC_BUS_IDLE;
          ack_q <= 1'b0;
        end
      endcase
    end
  end

  // writable control bits take the new byte lanes, the rest stay
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d = (ctrl_q & ~(lane_mask & `DCC_CTRL_WR_MASK)) |
               (wb_dat_i[15:0] & lane_mask & `DCC_CTRL_WR_MASK);
    end
  end

  // control register; flags and results live elsewhere
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `DCC_CTRL_RST;
    end
    else if (ce_i)
    begin
      ctrl_q <= ctrl_d;
    end
  end

  // writing a zero to a selected flag bit clears it
  assign flag_clr = {2{wr_ctrl & wb_sel_i[1]}} &
                    ~wb_dat_i[`DCC_BIT_FLAG + 1:`DCC_BIT_FLAG];

  // change flags: a change in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_q <= `DCC_IRQ_RST;
    end
    else if (ce_i)
    begin
      flag_q <= (flag_q & ~flag_clr) | change;
    end
  end

  // idle suppression holds off interrupt status while the part idles
  assign suppress = ctrl_q[`DCC_BIT_IDLE] & idle_i;
  assign irq_set = change & {2{~suppress}};

  // interrupt status, write one to clear, set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ists_q <= `DCC_IRQ_RST;
    end
    else if (ce_i)
    begin
      if (wr_ists & wb_sel_i[0])
      begin
        ists_q <= (ists_q & ~wb_dat_i[1:0]) | irq_set;
      end
      else
      begin
        ists_q <= ists_q | irq_set;
      end
    end
  end

  // interrupt mask, one enables the matching status bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      imsk_q <= `DCC_IRQ_RST;
    end
    else if (ce_i)
    begin
      if (wr_imsk & wb_sel_i[0])
      begin
        imsk_q <= wb_dat_i[1:0];
      end
    end
  end

  // level interrupt, one cycle behind the status and mask
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_q <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_q <= |(ists_q & imsk_q) & ~suppress;
    end
  end

  // read view of the control register, bit 14 stays zero
  always_comb
  begin
    ctrl_rd = ctrl_q & `DCC_CTRL_WR_MASK;
    ctrl_rd[`DCC_BIT_FLAG + 1:`DCC_BIT_FLAG] = flag_q;
    ctrl_rd[`DCC_BIT_RES + 1:`DCC_BIT_RES] = result;
  end

  // read mux, unmapped addresses read zero
  always_comb
  begin
    rdat_d = `DCC_ZERO32;
    unique case (wb_adr_i)
      `DCC_ADR_CTRL: rdat_d = {`DCC_ZERO16, ctrl_rd};
      `DCC_ADR_ISTS: rdat_d = {30'h00000000, ists_q};
      `DCC_ADR_IMSK: rdat_d = {30'h00000000, imsk_q};
      default: rdat_d = `DCC_ZERO32;
    endcase
  end

  // read data is captured with the request and held with ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdat_q <= `DCC_ZERO32;
    end
    else if (ce_i)
    begin
      if (req & ~wb_we_i)
      begin
        rdat_q <= rdat_d;
      end
      else if (bus_q == dcc_pkg::DCC_BUS_ACK)
      begin
        rdat_q <= `DCC_ZERO32;
      end
    end
  end

  // route selects go to the analog muxes straight from the register
  assign plus_route_o = {ctrl_q[`DCC_BIT_PLUS_B], ctrl_q[`DCC_BIT_PLUS_A]};
  assign minus_route_o = {ctrl_q[`DCC_BIT_MINUS_B], ctrl_q[`DCC_BIT_MINUS_A]};
  assign cmp_on_o = ctrl_q[`DCC_BIT_ON + 1:`DCC_BIT_ON];

  // one channel per comparator
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ch
      dcc_chan_if ch_if ();

      assign ch_if.on = ctrl_q[`DCC_BIT_ON + gi];
      assign ch_if.pad_drive = ctrl_q[`DCC_BIT_PAD + gi];
      assign ch_if.flip = ctrl_q[`DCC_BIT_FLIP + gi];
      assign result[gi] = ch_if.result;
      assign change[gi] = ch_if.change;
      assign pad_o[gi] = ch_if.pad;
      assign pad_oe_n_o[gi] = ch_if.pad_oe_n;

      dcc_chan u_chan (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i (ce_i),
        .raw_i (cmp_raw_i[gi]),
        .ch (ch_if.chan)
      );
    end
  endgenerate

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq_o = irq_q;

endmodule

//--- tb/dcc_cmp_model.sv
/*
  analog side model: two comparator cores sharing one pin pair and the
  internal reference level. assumes the bench sets the three levels.
*/
`timescale 1ns/1ps
module dcc_cmp_model (
  input wire logic clk_i,
  input wire logic [1:0] on_i,
  input wire logic [1:0] plus_route_i,
  input wire logic [1:0] minus_route_i,
  input wire logic [7:0] vp_i,
  input wire logic [7:0] vn_i,
  input wire logic [7:0] vref_i,
  output logic [1:0] raw_o
);
  logic [7:0] pl;
  logic [7:0] mi;
  logic junk_q = 1'b0;
  // a core that is off gives no settled answer
  always_ff @(posedge clk_i)
    junk_q <= ~junk_q;
  // route the inputs, then compare
  always_comb
    for (int k = 0; k < 2; k++)
    begin
      pl = plus_route_i[k] ? vp_i : vref_i;
      mi = minus_route_i[k] ? vp_i : vn_i;
      raw_o[k] = on_i[k] ? (pl > mi) : junk_q;
    end
endmodule

//--- tb/dcc_assertions.sv
/*
  port checker for the comparator control block.
  assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
module dcc_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic idle_i,
  input wire logic [1:0] cmp_raw_i,
  input wire logic [1:0] cmp_on_o,
  input wire logic [1:0] plus_route_o,
  input wire logic [1:0] minus_route_o,
  input wire logic [1:0] pad_o,
  input wire logic [1:0] pad_oe_n_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ctl;
  logic sup_q;
  // a control write being answered
  assign wr_ctl = wb_ack_o && wb_we_i && wb_adr_i == 8'h00;
  // shadow of the idle suppress bit
  always_ff @(posedge clk_i)
    if (rst_i)
      sup_q <= 1'b0;
    else if (wr_ctl && wb_sel_i[1])
      sup_q <= wb_dat_i[15];
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside answer");
  a_unused_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0 && !wb_dat_o[14])
    else $error("unused bits not zero");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=> cmp_on_o == 2'h0 &&
      pad_oe_n_o == 2'h3 && !irq_o && !wb_ack_o)
    else $error("outputs not cleared by reset");
  a_on_follow: assert property (wr_ctl && wb_sel_i[1] |=> cmp_on_o == $past(wb_dat_i[11:10]))
    else $error("enable outputs wrong");
  a_pad_enable: assert property (wr_ctl && wb_sel_i[1] |=> pad_oe_n_o == ~$past(wb_dat_i[9:8]))
    else $error("pad enable wrong");
  a_route_follow: assert property (wr_ctl && wb_sel_i[0] |=>
      plus_route_o == {$past(wb_dat_i[2]), $past(wb_dat_i[0])} &&
      minus_route_o == {$past(wb_dat_i[3]), $past(wb_dat_i[1])})
    else $error("route outputs wrong");
  a_off_pad_low: assert property ((cmp_on_o == 2'h0) [*3] |-> pad_o == 2'h0)
    else $error("pad driven by an idle comparator");
  a_idle_quiet: assert property (sup_q && idle_i && $past(idle_i) |-> !irq_o)
    else $error("interrupt while idle suppressed");
endmodule
bind dcc_top dcc_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .idle_i(idle_i), .cmp_raw_i(cmp_raw_i), .cmp_on_o(cmp_on_o), .plus_route_o(plus_route_o),
  .minus_route_o(minus_route_o), .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o), .irq_o(irq_o));

//--- tb/tb_dcc_top.sv
/*
  bench for the comparator control block: bus tasks and call sequences.
  assumes the analog model stands in for the comparator cores.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
  $display("Error %0t got %h want %h", $time, a, b); end end
module tb_dcc_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic stb = 1'b0;
  logic idle = 1'b0;
  logic ce = 1'b1;
  logic [7:0] vp = 8'h10;
  logic [7:0] vn = 8'h20;
  logic [7:0] vref = 8'h30;
  logic [31:0] dat;
  logic [31:0] rd;
  logic ack, irq, x;
  logic [1:0] raw, on, pr, mr, pad, oen;
  int bad_count = 0;
  int checked = 0;
  // 200 MHz clock
  initial
    forever #2.5 clk_i = ~clk_i;
  dcc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb),
    .wb_dat_o(dat), .wb_ack_o(ack), .idle_i(idle), .cmp_raw_i(raw), .cmp_on_o(on),
    .plus_route_o(pr), .minus_route_o(mr), .pad_o(pad), .pad_oe_n_o(oen), .irq_o(irq));
  dcc_cmp_model i_cmp (.clk_i(clk_i), .on_i(on), .plus_route_i(pr), .minus_route_i(mr),
    .vp_i(vp), .vn_i(vn), .vref_i(vref), .raw_o(raw));
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w,
    input logic [3:0] s);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    we <= w;
    sel <= s;
    stb <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20)
    begin
      bad_count++;
      $display("Error %0t bus timeout", $time);
      end_sim();
    end
    rd = dat;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, d, 1'b1, 4'h3);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0, 4'h3);
    `CHK(rd, e)
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(oen, 2'h3)
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    wr(8'h00, 32'h4f0f);
    // the synchronisers still hold samples of the off cores for a few cycles
    repeat (4) @(posedge clk_i);
    rdchk(8'h00, 32'h0f0f);
    `CHK(oen, 2'h0)
    `CHK(on, 2'h3)
    for (int i = 0; i < 8; i++)
    begin
      x = i[2] ^ ((i[0] ? vp : vref) > (i[1] ? vp : vn));
      wr(8'h00, 32'h0f00 | {26'h0, i[2], i[2], i[1], i[0], i[1], i[0]});
      repeat (6) @(posedge clk_i);
      bus(8'h00, 32'h0, 1'b0, 4'h3);
      `CHK(rd[7:6], {x, x})
      `CHK(pad, {x, x})
      `CHK(pr, {i[0], i[0]})
      `CHK(mr, {i[1], i[1]})
    end
    wr(8'h00, 32'h0f30);
    repeat (6) @(posedge clk_i);
    rdchk(8'h00, 32'h3f30);
    wr(8'h00, 32'h3f30);
    rdchk(8'h00, 32'h3f30);
    wr(8'h00, 32'h0f30);
    rdchk(8'h00, 32'h0f30);
    rdchk(8'h04, 32'h3);
    `CHK(irq, 1'b0)
    wr(8'h08, 32'h1);
    `CHK(irq, 1'b1)
    wr(8'h04, 32'h1);
    `CHK(irq, 1'b0)
    rdchk(8'h04, 32'h2);
    vn <= 8'h40;
    repeat (6) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wr(8'h08, 32'h0);
    `CHK(irq, 1'b0)
    rdchk(8'h00, 32'h3ff0);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h8f30);
    wr(8'h08, 32'h3);
    idle <= 1'b1;
    vn <= 8'h20;
    repeat (6) @(posedge clk_i);
    `CHK(irq, 1'b0)
    rdchk(8'h04, 32'h0);
    rdchk(8'h00, 32'hbf30);
    idle <= 1'b0;
    vn <= 8'h40;
    repeat (6) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wr(8'h04, 32'h3);
    // clock enable low: a result change must not move any state
    ce <= 1'b0;
    vn <= 8'h20;
    repeat (8) @(posedge clk_i);
    `CHK(irq, 1'b0)
    ce <= 1'b1;
    repeat (7) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h0);
    repeat (8) @(posedge clk_i);
    rdchk(8'h00, 32'h0);
    `CHK(pad, 2'h0)
    wr(8'h0c, 32'hffff);
    rdchk(8'h0c, 32'h0);
    bus(8'h00, 32'hffff, 1'b1, 4'h0);
    rdchk(8'h00, 32'h0);
    wr(8'h00, 32'h0f0f);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK(oen, 2'h3)
    rdchk(8'h00, 32'h0);
    end_sim();
  end
endmodule
